// ==== pkg/ctw_pkg.sv ====
// Constants and types for the CAN transceiver mode and wake block.
// ==========================================================================
// Operation
// RULE_01: Off mode follows power-up, is always allowed and stops the bus. In host fail-safe the code replaces an off write with wake.
// RULE_02: In off mode bus wake activity is ignored and no wake is flagged.
// RULE_03: Mode control bits from the serial interface select the mode.
// RULE_04: Normal mode is enabled by a serial write in host normal mode.
// RULE_05: Normal mode is permitted only in host normal or stop mode.
// RULE_06: In normal mode a low input drives dominant, a high one recessive.
// RULE_07: Controller holds the input high until the enabling time is over.
// RULE_08: Early dominant is dropped; sending waits for the input to go high.
// RULE_09: Receive output shows bus state, low dominant, high recessive.
// RULE_10: Receive-only mode disables the driver and keeps reception running.
// RULE_11: Receive-only mode is selectable only in host normal or stop mode.
// RULE_12: Wake mode watches the bus; allowed in stop, sleep, restart, normal.
// RULE_13: Host fail-safe mode forces wake-capable mode without any command.
// RULE_14: A wake needs two dominant phases between filter and limit time.
// RULE_15: A recessive phase in the same window splits the two phases.
// RULE_16: After a wake the receive output stays low until the mode changes.
// RULE_17: After a wake the controller may select normal mode serially.
// RULE_18: After wake the mode still reads wake and receive stays low.
// RULE_19: Wake rearms on a mode toggle or on host stop or fail-safe entry.
// RULE_20: Counters with constant limits measure filter and enabling times.
package ctw_pkg;

	// ==========================================================================
	// Encodings
	localparam logic [1:0] CTW_MODE_OFF   = 2'h0;
	localparam logic [1:0] CTW_MODE_WAKE  = 2'h1;
	localparam logic [1:0] CTW_MODE_RXO   = 2'h2;
	localparam logic [1:0] CTW_MODE_NORM  = 2'h3;

	localparam logic [2:0] CTW_HOST_NORMAL   = 3'h0;
	localparam logic [2:0] CTW_HOST_STOP     = 3'h1;
	localparam logic [2:0] CTW_HOST_SLEEP    = 3'h2;
	localparam logic [2:0] CTW_HOST_RESTART  = 3'h3;
	localparam logic [2:0] CTW_HOST_FAILSAFE = 3'h4;

	// ==========================================================================
	// Timing
	localparam int CTW_CLK_MHZ      = 125;
	localparam int CTW_WAKE_MIN_NS  = 500;
	localparam int CTW_WAKE_MAX_US  = 5;
	localparam int CTW_EN_TIME_US   = 20;
	localparam int CTW_WAKE_MIN_CYC =
		(CTW_WAKE_MIN_NS * CTW_CLK_MHZ + 999) / 1000;
	localparam int CTW_WAKE_MAX_CYC = CTW_WAKE_MAX_US * CTW_CLK_MHZ;
	localparam int CTW_EN_CYC       = CTW_EN_TIME_US * CTW_CLK_MHZ;
	localparam int CTW_CNT_W        = 12;

	// ==========================================================================
	// Carriers
	typedef struct packed {
		logic       wr;
		logic [1:0] mode;
	} ctw_cmd_t;

	typedef struct packed {
		logic drv_en;
		logic dominant;
	} ctw_drv_t;

endpackage

// ==== rtl/ctw_sync.sv ====
// Two flip-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
module ctw_sync (
	input  wire logic i_core_clk,
	input  wire logic i_rst_b,
	input  wire logic i_async,
	output logic      o_sync
);
	import ctw_pkg::*;

	logic meta_r;

	// ==========================================================================
	// Stages
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_r <= 1'b1;
			o_sync <= 1'b1;
		end else begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule

// ==== rtl/ctw_wake_det.sv ====
// Wake pattern detector: dominant, recessive, dominant phases in a time window.
`timescale 1ns/1ps
module ctw_wake_det #(
	parameter int MIN_CYC = ctw_pkg::CTW_WAKE_MIN_CYC,
	parameter int MAX_CYC = ctw_pkg::CTW_WAKE_MAX_CYC
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst_b,
	input  wire logic i_arm,
	input  wire logic i_bus_rec,
	output logic      o_wake
);
	import ctw_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_DOM1, S_REC, S_DOM2} ctw_wst_t;

	ctw_wst_t             st_r;
	ctw_wst_t             st_nxt;
	logic [CTW_CNT_W-1:0] cnt_r;
	logic                 prev_r;
	logic                 edge_w;
	logic                 long_w;
	logic                 ok_w;
	logic                 hit_w;

	assign edge_w = i_bus_rec != prev_r;
	assign long_w = cnt_r >= CTW_CNT_W'(MAX_CYC - 1);
	assign ok_w   = cnt_r >= CTW_CNT_W'(MIN_CYC) && !long_w; // RULE_14 RULE_15
	assign hit_w  = st_r == S_DOM2 && ok_w && edge_w;       // RULE_14

	// ==========================================================================
	// Phase sequence
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			S_IDLE:  if (edge_w && !i_bus_rec) st_nxt = S_DOM1;
			S_DOM1:  if (long_w) st_nxt = S_IDLE;
				else if (edge_w) st_nxt = ok_w ? S_REC : S_IDLE;
			S_REC:   if (long_w) st_nxt = S_IDLE;
				else if (edge_w) st_nxt = ok_w ? S_DOM2 : S_DOM1; // RULE_15
			S_DOM2:  if (long_w || edge_w) st_nxt = S_IDLE;
			default: st_nxt = S_IDLE;
		endcase
		if (!i_arm) st_nxt = S_IDLE; // RULE_02
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st_r   <= S_IDLE;
			cnt_r  <= '0;
			prev_r <= 1'b1;
			o_wake <= 1'b0;
		end else begin
			st_r   <= st_nxt;
			prev_r <= i_bus_rec;
			cnt_r  <= (edge_w || st_nxt != st_r) ? '0 :
				(long_w ? cnt_r : cnt_r + 1'b1); // RULE_20
			o_wake <= hit_w && i_arm;
		end
	end

	property p_wake_needs_arm;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		o_wake |-> $past(i_arm);
	endproperty
	a_wake_needs_arm: assert property (p_wake_needs_arm) // RULE_02
		else $error("Wake raised while not armed.");

	property p_wake_after_dom2;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		o_wake |-> $past(st_r) == S_DOM2 && $past(i_bus_rec);
	endproperty
	a_wake_after_dom2: assert property (p_wake_after_dom2) // RULE_14
		else $error("Wake without second dominant phase.");
endmodule

// ==== rtl/ctw_ctrl.sv ====
// CAN transceiver mode control, transmit enabling and wake signalling.
`timescale 1ns/1ps
module ctw_ctrl #(
	parameter int EN_CYC = ctw_pkg::CTW_EN_CYC
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_b,
	input  wire logic [2:0]       i_host_mode,
	input  wire ctw_pkg::ctw_cmd_t i_cmd,
	input  wire logic             i_tx_data_in,
	input  wire logic             i_bus_rec,
	output ctw_pkg::ctw_drv_t     o_drv,
	output logic                  o_rx_data,
	output logic [1:0]            o_mode,
	output logic                  o_wake_pattern
);
	import ctw_pkg::*;

	logic [1:0]           mode_r;
	logic [1:0]           mode_nxt;
	logic [2:0]           host_prev_r;
	logic                 woke_r;
	logic                 armed_r;
	logic                 tx_ok_r;
	logic [CTW_CNT_W-1:0] en_cnt_r;
	logic                 tx_s;
	logic                 bus_s;
	logic                 wake_w;
	logic                 host_ns;
	logic                 cmd_ok;
	logic                 host_fs;
	logic                 host_entry;
	logic                 rearm_w;
	logic                 en_done;
	logic                 mode_chg;
	logic                 arm_w;

	// ==========================================================================
	// Pin synchronisers
	ctw_sync u_tx_sync (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_async    (i_tx_data_in),
		.o_sync     (tx_s)
	);

	ctw_sync u_bus_sync (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_async    (i_bus_rec),
		.o_sync     (bus_s)
	);

	// ==========================================================================
	// Mode selection
	assign host_ns = i_host_mode == CTW_HOST_NORMAL ||
		i_host_mode == CTW_HOST_STOP;
	assign host_fs = i_host_mode == CTW_HOST_FAILSAFE;
	assign host_entry = i_host_mode != host_prev_r;

	always_comb begin
		case (i_cmd.mode)
			CTW_MODE_OFF:  cmd_ok = 1'b1;                      // RULE_01
			CTW_MODE_NORM: cmd_ok = host_ns;                   // RULE_04 RULE_05
			CTW_MODE_RXO:  cmd_ok = host_ns;                   // RULE_11
			CTW_MODE_WAKE: cmd_ok = !host_fs;                  // RULE_12
			default:       cmd_ok = 1'b0;
		endcase
	end

	always_comb begin
		mode_nxt = mode_r;
		if (i_cmd.wr && cmd_ok) mode_nxt = i_cmd.mode;        // RULE_03
		if (!host_ns && (mode_nxt == CTW_MODE_NORM ||
			mode_nxt == CTW_MODE_RXO)) mode_nxt = CTW_MODE_WAKE; // RULE_05
		if (host_fs) mode_nxt = CTW_MODE_WAKE;                  // RULE_13
	end

	assign mode_chg = mode_nxt != mode_r;
	assign rearm_w  = mode_chg || (host_entry &&
		(i_host_mode == CTW_HOST_STOP || host_fs)); // RULE_19
	assign en_done  = en_cnt_r >= CTW_CNT_W'(EN_CYC);
	assign arm_w    = armed_r && mode_r == CTW_MODE_WAKE; // RULE_12 RULE_19

	// ==========================================================================
	// Wake detection
	ctw_wake_det u_wake (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_arm      (arm_w),
		.i_bus_rec  (bus_s),
		.o_wake     (wake_w)
	);

	// ==========================================================================
	// State registers
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode_r      <= CTW_MODE_OFF; // RULE_01
			host_prev_r <= CTW_HOST_NORMAL;
			woke_r      <= 1'b0;
			armed_r     <= 1'b1;
			en_cnt_r    <= '0;
			tx_ok_r     <= 1'b0;
		end else begin
			mode_r      <= mode_nxt;
			host_prev_r <= i_host_mode;
			// The wake flag holds until the mode changes (set wins otherwise).
			if (wake_w && mode_r == CTW_MODE_WAKE) woke_r <= 1'b1; // RULE_16 RULE_18
			else if (mode_chg) woke_r <= 1'b0;                      // RULE_16
			if (wake_w) armed_r <= 1'b0;
			else if (rearm_w) armed_r <= 1'b1;                      // RULE_19
			if (mode_r != CTW_MODE_NORM || mode_chg) en_cnt_r <= '0;
			else if (!en_done) en_cnt_r <= en_cnt_r + 1'b1;         // RULE_20
			if (mode_r != CTW_MODE_NORM || mode_chg) tx_ok_r <= 1'b0;
			else if (en_done && tx_s) tx_ok_r <= 1'b1;              // RULE_08
		end
	end

	// ==========================================================================
	// Outputs
	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_drv          <= '0;
			o_rx_data      <= 1'b1;
			o_wake_pattern <= 1'b0;
		end else begin
			o_drv.drv_en   <= mode_r == CTW_MODE_NORM && tx_ok_r;   // RULE_10
			o_drv.dominant <= mode_r == CTW_MODE_NORM && tx_ok_r
				&& !tx_s;                                            // RULE_06
			if (mode_r == CTW_MODE_NORM || mode_r == CTW_MODE_RXO)
				o_rx_data <= bus_s;                                  // RULE_09
			else
				o_rx_data <= !(woke_r && mode_r == CTW_MODE_WAKE);   // RULE_16
			o_wake_pattern <= wake_w && mode_r == CTW_MODE_WAKE;
		end
	end

	assign o_mode = mode_r; // RULE_18

	// ==========================================================================
	// Checks
	property p_off_after_reset;
		@(posedge i_core_clk) $rose(i_rst_b) |-> mode_r == CTW_MODE_OFF;
	endproperty
	a_off_after_reset: assert property (p_off_after_reset) // RULE_01
		else $error("Mode not off after reset.");

	property p_off_quiet;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_r == CTW_MODE_OFF ##1 mode_r == CTW_MODE_OFF
			|-> !o_drv.drv_en && !o_wake_pattern;
	endproperty
	a_off_quiet: assert property (p_off_quiet) // RULE_02
		else $error("Activity in off mode.");

	property p_norm_host;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_r == CTW_MODE_NORM |-> $past(host_ns);
	endproperty
	a_norm_host: assert property (p_norm_host) // RULE_05
		else $error("Normal mode outside host normal or stop.");

	property p_rxo_host;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_r == CTW_MODE_RXO |-> $past(host_ns);
	endproperty
	a_rxo_host: assert property (p_rxo_host) // RULE_11
		else $error("Receive-only mode outside host normal or stop.");

	property p_failsafe_wake;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		host_fs |=> mode_r == CTW_MODE_WAKE;
	endproperty
	a_failsafe_wake: assert property (p_failsafe_wake) // RULE_13
		else $error("Fail-safe did not force wake-capable mode.");

	property p_rxo_no_drive;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_r == CTW_MODE_RXO |=> !o_drv.drv_en;
	endproperty
	a_rxo_no_drive: assert property (p_rxo_no_drive) // RULE_10
		else $error("Driver on in receive-only mode.");

	property p_no_early_tx;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		o_drv.dominant |-> $past(en_done);
	endproperty
	a_no_early_tx: assert property (p_no_early_tx) // RULE_08
		else $error("Dominant sent before enabling time.");

	property p_wake_rx_low;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		woke_r && mode_r == CTW_MODE_WAKE ##1 mode_r == CTW_MODE_WAKE
			|-> !o_rx_data;
	endproperty
	a_wake_rx_low: assert property (p_wake_rx_low) // RULE_16
		else $error("Receive output not low after wake.");

	property p_tx_follow;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_r == CTW_MODE_NORM && tx_ok_r && !mode_chg
			|=> o_drv.dominant == !$past(tx_s);
	endproperty
	a_tx_follow: assert property (p_tx_follow) // RULE_06
		else $error("Driver does not follow transmit input.");

	property p_off_any_host;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		i_cmd.wr && i_cmd.mode == CTW_MODE_OFF && !host_fs
			|=> mode_r == CTW_MODE_OFF;
	endproperty
	a_off_any_host: assert property (p_off_any_host) // RULE_01
		else $error("Off mode write not taken.");

	property p_drv_idle;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_r != CTW_MODE_NORM |=> !o_drv.drv_en && !o_drv.dominant;
	endproperty
	a_drv_idle: assert property (p_drv_idle) // RULE_01
		else $error("Driver active outside normal mode.");

	property p_mode_write;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		i_cmd.wr && cmd_ok && host_ns |=> mode_r == $past(i_cmd.mode);
	endproperty
	a_mode_write: assert property (p_mode_write) // RULE_03
		else $error("Allowed mode write not taken.");

	property p_norm_enable;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		i_cmd.wr && i_cmd.mode == CTW_MODE_NORM &&
			i_host_mode == CTW_HOST_NORMAL |=> mode_r == CTW_MODE_NORM;
	endproperty
	a_norm_enable: assert property (p_norm_enable) // RULE_04
		else $error("Normal mode not enabled in host normal mode.");

	property p_host_leave;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_r == CTW_MODE_NORM && !host_ns && !i_cmd.wr
			|=> mode_r == CTW_MODE_WAKE;
	endproperty
	a_host_leave: assert property (p_host_leave) // RULE_05
		else $error("Normal mode kept after host left normal or stop.");

	property p_rx_follow;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_r == CTW_MODE_NORM || mode_r == CTW_MODE_RXO
			|=> o_rx_data == $past(bus_s);
	endproperty
	a_rx_follow: assert property (p_rx_follow) // RULE_09
		else $error("Receive output does not follow the bus.");

	property p_rxo_refused;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		i_cmd.wr && i_cmd.mode == CTW_MODE_RXO && !host_ns
			|=> mode_r != CTW_MODE_RXO;
	endproperty
	a_rxo_refused: assert property (p_rxo_refused) // RULE_11
		else $error("Receive-only write taken in wrong host mode.");

	property p_wake_select;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		i_cmd.wr && i_cmd.mode == CTW_MODE_WAKE |=> mode_r == CTW_MODE_WAKE;
	endproperty
	a_wake_select: assert property (p_wake_select) // RULE_12
		else $error("Wake-capable write not taken.");

	property p_wake_rx;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		o_wake_pattern && mode_r == CTW_MODE_WAKE |=> !o_rx_data;
	endproperty
	a_wake_rx: assert property (p_wake_rx) // RULE_16
		else $error("Receive output not low after wake pulse.");

	property p_disarm;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		o_wake_pattern |-> !armed_r;
	endproperty
	a_disarm: assert property (p_disarm) // RULE_19
		else $error("Wake detection still armed after a wake.");

	property p_rearm_mode;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_chg && !wake_w |=> armed_r;
	endproperty
	a_rearm_mode: assert property (p_rearm_mode) // RULE_19
		else $error("Mode change did not rearm wake detection.");

	property p_rearm_host;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		i_host_mode != host_prev_r && !wake_w &&
			(i_host_mode == CTW_HOST_STOP ||
			i_host_mode == CTW_HOST_FAILSAFE) |=> armed_r;
	endproperty
	a_rearm_host: assert property (p_rearm_host) // RULE_19
		else $error("Host stop or fail-safe entry did not rearm.");

	property p_en_count;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_r == CTW_MODE_NORM && !mode_chg && !en_done
			|=> en_cnt_r == $past(en_cnt_r) + 1'b1;
	endproperty
	a_en_count: assert property (p_en_count) // RULE_20
		else $error("Enabling counter did not advance.");

	property p_en_hold;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		mode_r == CTW_MODE_NORM && !mode_chg && en_done |=> en_done;
	endproperty
	a_en_hold: assert property (p_en_hold) // RULE_20
		else $error("Enabling time lost while in normal mode.");

	property p_tx_gate;
		@(posedge i_core_clk) disable iff (!i_rst_b)
		$rose(tx_ok_r) |-> $past(en_done) && $past(tx_s);
	endproperty
	a_tx_gate: assert property (p_tx_gate) // RULE_08
		else $error("Transmit enabled without recessive after enabling.");
endmodule

// ==== testbench/ctw_bus_model.sv ====
// Model of the controller transmit pin and the wired CAN bus.
`timescale 1ns/1ps
module ctw_bus_model (
	input  wire logic              i_remote_dom,
	input  wire logic              i_tx_req,
	input  wire ctw_pkg::ctw_drv_t i_drv,
	output logic                   o_tx_data_in,
	output logic                   o_bus_rec
);
	import ctw_pkg::*;
	// =====================================================================
	// Controller pin
	// The pin rests recessive unless a dominant bit is requested.
	assign o_tx_data_in = !i_tx_req;
	// =====================================================================
	// Bus
	// Any dominant driver wins over the recessive bias.
	assign o_bus_rec = !((i_drv.drv_en & i_drv.dominant) | i_remote_dom);
endmodule

// ==== testbench/ctw_ctrl_tb_top.sv ====
// Self-checking bench for the transceiver mode and wake block.
`timescale 1ns/1ps
module ctw_ctrl_tb_top;
	import ctw_pkg::*;
	localparam int EN = 20;
	logic       i_core_clk = 1'b0;
	logic       i_rst_b    = 1'b0;
	logic [2:0] host       = CTW_HOST_NORMAL;
	ctw_cmd_t   cmd        = '0;
	logic       tx_req     = 1'b0;
	logic       rem        = 1'b0;
	logic       tx;
	logic       bus_rec;
	logic       rx;
	logic       wk;
	logic [1:0] mode;
	ctw_drv_t   drv;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         n_wake     = 0;

	always #4 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) if (wk === 1'b1) n_wake++;

	ctw_ctrl #(.EN_CYC(EN)) u_dut (
		.i_core_clk    (i_core_clk),
		.i_rst_b       (i_rst_b),
		.i_host_mode   (host),
		.i_cmd         (cmd),
		.i_tx_data_in  (tx),
		.i_bus_rec     (bus_rec),
		.o_drv         (drv),
		.o_rx_data     (rx),
		.o_mode        (mode),
		.o_wake_pattern(wk)
	);
	ctw_bus_model u_bus (
		.i_remote_dom(rem),
		.i_tx_req    (tx_req),
		.i_drv       (drv),
		.o_tx_data_in(tx),
		.o_bus_rec   (bus_rec)
	);

	// =====================================================================
	// Helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [1:0] m);
		cmd = '{wr: 1'b1, mode: m};
		cyc(1);
		cmd.wr = 1'b0;
		cyc(1);
	endtask
	task automatic pat(input int d1, input int r, input int d2);
		rem = 1'b1;
		cyc(d1);
		rem = 1'b0;
		cyc(r);
		rem = 1'b1;
		cyc(d2);
		rem = 1'b0;
		cyc(700);
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// =====================================================================
	// Scenarios
	task automatic t_modes();
		logic [1:0] exp;
		for (int h = 0; h < 4; h++) begin
			for (int m = 1; m < 4; m++) begin
				host = h[2:0];
				cyc(2);
				wr(m[1:0]);
				exp = (m == 1 || h < 2) ? m[1:0] : CTW_MODE_OFF;
				chk(mode === exp, "mode select");
				wr(CTW_MODE_OFF);
				chk(mode === CTW_MODE_OFF, "off select");
			end
		end
		host = CTW_HOST_FAILSAFE;
		cyc(4);
		chk(mode === CTW_MODE_WAKE, "failsafe mode");
		host = CTW_HOST_NORMAL;
		cyc(4);
		wr(CTW_MODE_NORM);
		host = CTW_HOST_SLEEP;
		cyc(2);
		chk(mode === CTW_MODE_WAKE, "host leave");
		host = CTW_HOST_NORMAL;
		cyc(2);
		wr(CTW_MODE_OFF);
	endtask
	task automatic t_tx();
		tx_req = 1'b1;
		wr(CTW_MODE_NORM);
		cyc(EN + 10);
		chk(drv === 2'b00 && rx === 1'b1, "early dominant sent");
		tx_req = 1'b0;
		cyc(5);
		tx_req = 1'b1;
		cyc(8);
		chk(drv === 2'b11 && rx === 1'b0, "dominant bit");
		tx_req = 1'b0;
		cyc(8);
		chk(drv === 2'b10 && rx === 1'b1, "recessive bit");
	endtask
	task automatic t_rxo();
		wr(CTW_MODE_RXO);
		tx_req = 1'b1;
		cyc(8);
		chk(drv === 2'b00, "driver on");
		rem = 1'b1;
		cyc(6);
		chk(rx === 1'b0, "rx dominant");
		rem = 1'b0;
		tx_req = 1'b0;
		cyc(6);
		chk(rx === 1'b1, "rx recessive");
		wr(CTW_MODE_OFF);
	endtask
	task automatic t_wake();
		pat(200, 200, 200);
		chk(n_wake === 0 && rx === 1'b1, "wake in off");
		wr(CTW_MODE_WAKE);
		pat(30, 200, 30);
		chk(n_wake === 0, "short phases");
		pat(200, 30, 200);
		chk(n_wake === 0, "short gap");
		pat(700, 200, 200);
		chk(n_wake === 0, "long phase");
		pat(200, 200, 200);
		chk(n_wake === 1 && rx === 1'b0, "wake missed");
		chk(mode === CTW_MODE_WAKE, "mode after wake");
		pat(200, 200, 200);
		chk(n_wake === 1 && rx === 1'b0, "not disarmed");
		wr(CTW_MODE_OFF);
		cyc(2);
		chk(rx === 1'b1, "rx not released");
		wr(CTW_MODE_WAKE);
		pat(200, 200, 200);
		chk(n_wake === 2, "toggle rearm");
		host = CTW_HOST_STOP;
		cyc(4);
		pat(200, 200, 200);
		chk(n_wake === 3, "stop rearm");
		wr(CTW_MODE_NORM);
		cyc(4);
		chk(mode === CTW_MODE_NORM && rx === 1'b1, "resume");
		host = CTW_HOST_NORMAL;
	endtask
	task automatic t_reset();
		wr(CTW_MODE_RXO);
		i_rst_b = 1'b0;
		cyc(2);
		chk(mode === CTW_MODE_OFF && rx === 1'b1 && drv === 2'b00, "reset");
		i_rst_b = 1'b1;
		cyc(2);
	endtask

	// =====================================================================
	// Sequence
	initial begin
		cyc(4);
		i_rst_b = 1'b1;
		cyc(2);
		chk(mode === CTW_MODE_OFF && rx === 1'b1, "power-up");
		t_modes();
		t_tx();
		t_rxo();
		t_wake();
		t_reset();
		final_report();
	end
	initial begin
		#400000;
		n_mismatch++;
		final_report();
	end
endmodule
